// ==== shared/drc_pkg.sv ====
// Package: register map, field codes, timing constants for the dual-rail control block
package drc_pkg;

  // ***********************************************
  // Register map (byte addresses)
  // ***********************************************
  localparam logic [5:0] ADDR_ONOFF = 6'h00;
  localparam logic [5:0] ADDR_OPER = 6'h04;
  localparam logic [5:0] ADDR_VIDSETUP = 6'h08;
  localparam logic [5:0] ADDR_NOMINAL = 6'h0c;
  localparam logic [5:0] ADDR_MARGHI = 6'h10;
  localparam logic [5:0] ADDR_MARGLO = 6'h14;
  localparam logic [5:0] ADDR_VIDCODE = 6'h18;
  localparam logic [5:0] ADDR_SAMPLE = 6'h1c;
  localparam logic [5:0] ADDR_GAINS = 6'h20;
  localparam logic [5:0] ADDR_SLEW = 6'h24;
  localparam logic [5:0] ADDR_STATUS = 6'h28;
  localparam logic [5:0] ADDR_ERRSENSE = 6'h2c;
  localparam logic [5:0] ADDR_REF = 6'h30;
  localparam logic [31:0] UNMAPPED_DATA = 32'hdeadbeef;

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int ONOFF_MODE_LSB = 0;
  localparam int ONOFF_POL_BIT = 4;
  localparam int OPER_ON_BIT = 0;
  localparam int OPER_MARG_LSB = 1;
  localparam int OPER_SUPP_BIT = 3;
  localparam int GAIN_BANK_W = 2;
  localparam int GAIN_LIGHT_BIT = 8;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [4:0] ONOFF_RST = 5'h13;
  localparam logic [3:0] OPER_RST = 4'h0;
  localparam logic [9:0] NOMINAL_RST = 10'h200;
  localparam logic [9:0] MARGHI_RST = 10'h220;
  localparam logic [9:0] MARGLO_RST = 10'h1e0;
  localparam logic [5:0] GAINS_RST = 6'h2a;
  localparam logic [7:0] SAMPLE_RST = 8'h20;
  localparam logic [15:0] SLEW_RST = 16'h0100;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_MHZ = 250;
  localparam int STARTUP_US = 10;
  localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
  // Saturation slew 0.156 V/ms at 1 mV per ref LSB: 156 LSB/ms
  localparam int SAT_SLEW_UV_PER_MS = 156000;
  localparam int REF_LSB_UV = 1000;
  localparam int SAT_STEP_CYCLES = (CLK_MHZ * 1000 * REF_LSB_UV) / SAT_SLEW_UV_PER_MS;
  localparam int CYCLE_LEN = 250;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_AUTO = 3'b001,
    MODE_PIN = 3'b010,
    MODE_CMD = 3'b011,
    MODE_BOTH = 3'b100
  } drc_onoff_t;

  typedef enum logic [1:0] {
    SEL_NOMINAL = 2'b00,
    SEL_MARGHI = 2'b01,
    SEL_MARGLO = 2'b10
  } drc_marg_t;

  typedef enum logic [1:0] {
    BANK_RAMP = 2'b00,
    BANK_REG = 2'b01,
    BANK_LIGHT = 2'b10
  } drc_bank_t;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } drc_req_t;

  typedef struct packed {
    logic signed [5:0] errCode;
    logic saturated;
  } drc_err_t;

endpackage

// ==== rtl/drc_sync.sv ====
// Two-flop synchroniser for a group of level inputs
module drc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

// ==== rtl/drc_error_conv.sv ====
// Error converter: difference, gain scaling and saturation to a 6-bit code
module drc_error_conv #(
  parameter int SENSE_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sampleStrobe,
  input wire logic [SENSE_W-1:0] senseMv,
  input wire logic [9:0] refMv,
  input wire logic [1:0] gainCode,
  output drc_pkg::drc_err_t errOut
);

  logic signed [SENSE_W+1:0] diff;
  logic signed [SENSE_W+1:0] scaled;

  always_comb begin
    diff = $signed({2'b00, senseMv}) - $signed({{(SENSE_W-8){1'b0}}, refMv});
    scaled = diff >>> (3 - gainCode);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      errOut <= '0;
    end else if (sampleStrobe) begin
      if (scaled > 31) begin
        errOut <= '{errCode: 6'sh1f, saturated: 1'b1};
      end else if (scaled < -32) begin
        errOut <= '{errCode: 6'sh20, saturated: 1'b1};
      end else begin
        errOut <= '{errCode: scaled[5:0], saturated: 1'b0};
      end
    end
  end

endmodule

// ==== rtl/drc_rail_ctrl.sv ====
// Dual-rail enable, power-good and setpoint control with Avalon-MM registers
module drc_rail_ctrl #(
  parameter int NUM_RAILS = 2,
  parameter int SENSE_W = 12,
  parameter int STARTUP_CYCLES = drc_pkg::STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_reset_low,
  input wire logic digital_supply_rail,
  input wire logic busCtrlPin,
  input wire logic rail1_enable_pin,
  input wire logic rail2_enable_pin,
  input wire logic [SENSE_W-1:0] rail1Sense,
  input wire logic [SENSE_W-1:0] rail2Sense,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic rail1_good_out,
  output logic rail1_good_oe,
  output logic rail2_good_out,
  output logic rail2_good_oe,
  output logic all_rails_good_out,
  output logic all_rails_good_oe,
  output logic [NUM_RAILS-1:0] railOn,
  output logic [NUM_RAILS-1:0] faultSuppress,
  output logic [NUM_RAILS*10-1:0] refCode
);

  // ***********************************************
  // Input synchronisation
  // ***********************************************
  logic [3:0] syncIn;
  logic extResetLowS;
  logic supplyS;
  logic ctrlS;
  logic [NUM_RAILS-1:0] enS;

  drc_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .async({ext_reset_low, digital_supply_rail, busCtrlPin, 1'b0}),
    .synced(syncIn)
  );

  drc_sync #(.WIDTH(NUM_RAILS)) u_sync_en (
    .clk(clk),
    .reset(reset),
    .async({rail2_enable_pin, rail1_enable_pin}),
    .synced(enS)
  );

  assign extResetLowS = syncIn[3];
  assign supplyS = syncIn[2];
  assign ctrlS = syncIn[1];

  // ***********************************************
  // Registers
  // ***********************************************
  logic [4:0] onOffCfg;
  logic [3:0] operCmd;
  logic vidSelect;
  logic [9:0] nominal;
  logic [9:0] margHi;
  logic [9:0] margLo;
  logic [9:0] vidCode;
  logic [7:0] sampleTime;
  logic [8:0] gains;
  logic [15:0] slewDiv;
  logic running;
  logic inReset;

  drc_pkg::drc_req_t req;
  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};

  // One wait state per access: answer on second cycle
  logic ackPhase;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackPhase <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ackPhase <= (req.read || req.write) && !ackPhase;
      avs_waitrequest <= !((req.read || req.write) && !ackPhase);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      onOffCfg <= drc_pkg::ONOFF_RST;
      operCmd <= drc_pkg::OPER_RST;
      vidSelect <= 1'b0;
      nominal <= drc_pkg::NOMINAL_RST;
      margHi <= drc_pkg::MARGHI_RST;
      margLo <= drc_pkg::MARGLO_RST;
      vidCode <= drc_pkg::NOMINAL_RST;
      sampleTime <= drc_pkg::SAMPLE_RST;
      gains <= {3'b000, drc_pkg::GAINS_RST};
      slewDiv <= drc_pkg::SLEW_RST;
    end else if (req.write && ackPhase) begin
      unique case (req.address)
        drc_pkg::ADDR_ONOFF: onOffCfg <= req.writedata[4:0];
        drc_pkg::ADDR_OPER: operCmd <= req.writedata[3:0];
        drc_pkg::ADDR_VIDSETUP: vidSelect <= req.writedata[0];
        drc_pkg::ADDR_NOMINAL: nominal <= req.writedata[9:0];
        drc_pkg::ADDR_MARGHI: margHi <= req.writedata[9:0];
        drc_pkg::ADDR_MARGLO: margLo <= req.writedata[9:0];
        drc_pkg::ADDR_VIDCODE: vidCode <= req.writedata[9:0];
        drc_pkg::ADDR_SAMPLE: sampleTime <= req.writedata[7:0];
        drc_pkg::ADDR_GAINS: gains <= req.writedata[8:0];
        drc_pkg::ADDR_SLEW: slewDiv <= req.writedata[15:0];
        default: ;
      endcase
    end
  end

  // ***********************************************
  // Reset and startup
  // ***********************************************
  logic [$clog2(STARTUP_CYCLES+1)-1:0] startCnt;

  assign inReset = !extResetLowS;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      startCnt <= '0;
      running <= 1'b0;
    end else if (inReset || !supplyS) begin
      startCnt <= '0;
      running <= 1'b0;
    end else if (!running) begin
      if (startCnt == ($clog2(STARTUP_CYCLES+1))'(STARTUP_CYCLES - 1)) begin
        running <= 1'b1;
      end
      startCnt <= startCnt + 1'b1;
    end
  end

  // ***********************************************
  // Rail on/off decision
  // ***********************************************
  function automatic logic pinActive(input logic level, input logic pol);
    return pol ? level : !level;
  endfunction

  logic ctrlActive;
  logic cmdOn;
  logic [NUM_RAILS-1:0] next_railOn;

  always_comb begin
    ctrlActive = pinActive(ctrlS, onOffCfg[drc_pkg::ONOFF_POL_BIT]);
    cmdOn = operCmd[drc_pkg::OPER_ON_BIT];
    for (int r = 0; r < NUM_RAILS; r++) begin
      logic pinOn;
      pinOn = 1'b0;
      pinOn = ctrlActive && pinActive(enS[r], onOffCfg[drc_pkg::ONOFF_POL_BIT]);
      unique case (drc_pkg::drc_onoff_t'(onOffCfg[2:0]))
        drc_pkg::MODE_OFF: next_railOn[r] = 1'b0;
        drc_pkg::MODE_AUTO: next_railOn[r] = 1'b1;
        drc_pkg::MODE_PIN: next_railOn[r] = pinOn;
        drc_pkg::MODE_CMD: next_railOn[r] = cmdOn;
        drc_pkg::MODE_BOTH: next_railOn[r] = pinOn && cmdOn;
        default: next_railOn[r] = 1'b0;
      endcase
      if (!running) begin
        next_railOn[r] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      railOn <= '0;
    end else begin
      railOn <= next_railOn;
    end
  end

  // ***********************************************
  // Setpoint selection and slewing
  // ***********************************************
  logic [9:0] target;
  logic [NUM_RAILS-1:0] atTarget;
  logic [NUM_RAILS-1:0] sat;
  logic [NUM_RAILS-1:0] satHigh;
  logic [15:0] slewCnt;
  logic [15:0] satCnt;

  always_comb begin
    target = nominal;
    if (vidSelect) begin
      target = vidCode;
    end else begin
      unique case (drc_pkg::drc_marg_t'(operCmd[2:1]))
        drc_pkg::SEL_MARGHI: target = margHi;
        drc_pkg::SEL_MARGLO: target = margLo;
        default: target = nominal;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slewCnt <= '0;
      satCnt <= '0;
    end else begin
      slewCnt <= (slewCnt >= slewDiv) ? '0 : slewCnt + 1'b1;
      satCnt <= (satCnt >= 16'(drc_pkg::SAT_STEP_CYCLES - 1)) ? '0 : satCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refCode <= {NUM_RAILS{drc_pkg::NOMINAL_RST}};
    end else begin
      for (int r = 0; r < NUM_RAILS; r++) begin
        if (sat[r] && satCnt == '0) begin
          refCode[r*10 +: 10] <= satHigh[r] ? refCode[r*10 +: 10] + 10'h001 : refCode[r*10 +: 10] - 10'h001;
        end else if (!sat[r] && slewCnt == '0) begin
          if (refCode[r*10 +: 10] < target) begin
            refCode[r*10 +: 10] <= refCode[r*10 +: 10] + 10'h001;
          end else if (refCode[r*10 +: 10] > target) begin
            refCode[r*10 +: 10] <= refCode[r*10 +: 10] - 10'h001;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      faultSuppress <= '0;
    end else begin
      faultSuppress <= {NUM_RAILS{operCmd[drc_pkg::OPER_SUPP_BIT] && !vidSelect && operCmd[2:1] != 2'b00}};
    end
  end

  // ***********************************************
  // Front end sampling
  // ***********************************************
  logic [7:0] phaseCnt;
  logic sampleStrobe;
  drc_pkg::drc_err_t errOut [NUM_RAILS];
  logic [1:0] bankGain;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phaseCnt <= '0;
    end else begin
      phaseCnt <= (phaseCnt == 8'(drc_pkg::CYCLE_LEN - 1)) ? '0 : phaseCnt + 1'b1;
    end
  end

  assign sampleStrobe = (phaseCnt == sampleTime);

  always_comb begin
    if (!(&atTarget)) begin
      bankGain = gains[drc_pkg::BANK_RAMP*drc_pkg::GAIN_BANK_W +: drc_pkg::GAIN_BANK_W];
    end else if (gains[drc_pkg::GAIN_LIGHT_BIT]) begin
      bankGain = gains[drc_pkg::BANK_LIGHT*drc_pkg::GAIN_BANK_W +: drc_pkg::GAIN_BANK_W];
    end else begin
      bankGain = gains[drc_pkg::BANK_REG*drc_pkg::GAIN_BANK_W +: drc_pkg::GAIN_BANK_W];
    end
  end

  for (genvar r = 0; r < NUM_RAILS; r++) begin : g_afe
    drc_error_conv #(.SENSE_W(SENSE_W)) u_conv (
      .clk(clk),
      .reset(reset),
      .sampleStrobe(sampleStrobe),
      .senseMv(r == 0 ? rail1Sense : rail2Sense),
      .refMv(refCode[r*10 +: 10]),
      .gainCode(bankGain),
      .errOut(errOut[r])
    );
    assign sat[r] = errOut[r].saturated;
    assign satHigh[r] = !errOut[r].errCode[5];
    assign atTarget[r] = (refCode[r*10 +: 10] == target);
  end

  // ***********************************************
  // Power good, open drain
  // ***********************************************
  logic [NUM_RAILS-1:0] good;
  assign good = railOn & atTarget & ~sat;

  // low when disabled; drive low only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rail1_good_oe <= 1'b1;
      rail2_good_oe <= 1'b1;
      all_rails_good_oe <= 1'b1;
    end else begin
      rail1_good_oe <= !good[0];
      rail2_good_oe <= !good[1];
      all_rails_good_oe <= !(&good);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rail1_good_out <= 1'b0;
      rail2_good_out <= 1'b0;
      all_rails_good_out <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rail1_good_out <= 1'b0;
      rail2_good_out <= 1'b0;
      all_rails_good_out <= 1'b0;
      if (req.read && !ackPhase) begin
        unique case (req.address)
          drc_pkg::ADDR_ONOFF: avs_readdata <= 32'(onOffCfg);
          drc_pkg::ADDR_OPER: avs_readdata <= 32'(operCmd);
          drc_pkg::ADDR_VIDSETUP: avs_readdata <= 32'(vidSelect);
          drc_pkg::ADDR_NOMINAL: avs_readdata <= 32'(nominal);
          drc_pkg::ADDR_MARGHI: avs_readdata <= 32'(margHi);
          drc_pkg::ADDR_MARGLO: avs_readdata <= 32'(margLo);
          drc_pkg::ADDR_VIDCODE: avs_readdata <= 32'(vidCode);
          drc_pkg::ADDR_SAMPLE: avs_readdata <= 32'(sampleTime);
          drc_pkg::ADDR_GAINS: avs_readdata <= 32'(gains);
          drc_pkg::ADDR_SLEW: avs_readdata <= 32'(slewDiv);
          drc_pkg::ADDR_STATUS: avs_readdata <= 32'({sat, good, railOn, running});
          drc_pkg::ADDR_ERRSENSE: avs_readdata <= 32'({errOut[1].errCode, errOut[0].errCode});
          drc_pkg::ADDR_REF: avs_readdata <= 32'(refCode);
          default: avs_readdata <= drc_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

endmodule

// ==== testbench/drc_ext_side.sv ====
// Model of the external enable and reset logic and the good-line pull-ups
module drc_ext_side (
  input wire logic activeHigh,
  input wire logic holdReset,
  input wire logic supplyUp,
  input wire logic [2:0] wantOn,
  input wire logic [2:0] goodOe,
  input wire logic [2:0] goodOut,
  output logic extResetLow,
  output logic supplyRail,
  output logic [2:0] enPins,
  output logic [2:0] goodLevel
);
  // ****************************************
  // Pin drive
  // ****************************************
  // low holds reset
  assign extResetLow = !holdReset;
  assign supplyRail = supplyUp;
  assign enPins = activeHigh ? wantOn : ~wantOn;
  assign goodLevel = (goodOe & goodOut) | ~goodOe;
endmodule

// ==== testbench/drc_rail_ctrl_props.sv ====
// Concurrent checks on the ports of the dual-rail control block
module drc_rail_ctrl_props #(
  parameter int NUM_RAILS = 2,
  parameter int STARTUP_CYCLES = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_reset_low,
  input wire logic digital_supply_rail,
  input wire logic rail1_enable_pin,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rail1_good_out,
  input wire logic rail1_good_oe,
  input wire logic rail2_good_out,
  input wire logic rail2_good_oe,
  input wire logic all_rails_good_out,
  input wire logic all_rails_good_oe,
  input wire logic [NUM_RAILS-1:0] railOn,
  input wire logic [NUM_RAILS*10-1:0] refCode
);
  // ****************************************
  // Helper count and assertions
  // ****************************************
  logic [15:0] upCount;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // cycles with reset released and supply up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      upCount <= 16'h0000;
    end else if (!(ext_reset_low && digital_supply_rail)) begin
      upCount <= 16'h0000;
    end else if (upCount != 16'hffff) begin
      upCount <= upCount + 16'h0001;
    end
  end

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |-> (avs_read || avs_write) ##1 avs_waitrequest)
    else $error("waitrequest low without request or too long");
  a_good_needs_on: assert property (
    (!rail1_good_oe |-> railOn[0] || $past(railOn[0])) and (!rail2_good_oe |-> railOn[1] || $past(railOn[1])))
    else $error("good released while rail off");
  a_all_good_and: assert property (!all_rails_good_oe |-> !rail1_good_oe && !rail2_good_oe)
    else $error("combined good without every rail good");
  a_drain_only: assert property (!(rail1_good_out || rail2_good_out || all_rails_good_out))
    else $error("good line driven high");
  a_ext_reset_off: assert property (!ext_reset_low [*6] |-> railOn == '0 && rail1_good_oe && rail2_good_oe)
    else $error("rail on during external reset");
  a_startup_gate: assert property ($rose(|railOn) |-> upCount >= STARTUP_CYCLES)
    else $error("rail on before startup count");
  a_pin_sync: assert property ($changed(rail1_enable_pin) |=> $stable(railOn[0]))
    else $error("enable pin used without synchronising");
  a_ref_slew: assert property ($changed(refCode[9:0]) |->
    (refCode[9:0] - $past(refCode[9:0])) == 10'h001 || (refCode[9:0] - $past(refCode[9:0])) == 10'h3ff)
    else $error("reference stepped by more than one");
endmodule

// ==== testbench/dual_rail_enable_setpoint_ctrl_tb.sv ====
// Self-checking testbench of the dual-rail control block
module dual_rail_enable_setpoint_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam logic [15:0] CFG [10] = '{16'h1017, 16'h1100, 16'h1203, 16'h1206, 16'h0205,
    16'h1310, 16'h1301, 16'h1416, 16'h1417, 16'h0417};
  localparam logic [1:0] EXP [10] = '{2'b00, 2'b11, 2'b01, 2'b00, 2'b10, 2'b11, 2'b00, 2'b00, 2'b11, 2'b11};
  localparam logic [31:0] GAIN [6] = '{32'h000, 32'h015, 32'h02a, 32'h00f, 32'h133, 32'h030};
  logic clk, reset, avsRead, avsWrite, avsWaitrequest, activeHigh, holdReset, supplyUp, extResetLow, supplyRail;
  logic [5:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [11:0] sense1, sense2;
  logic [2:0] wantOn, enPins, goodOe, goodOut, goodLevel;
  logic [1:0] railOn, faultSuppress;
  logic [19:0] refCode;
  logic [5:0] ra [8];
  logic [31:0] rv [8];
  int nFail = 0;
  int nChecks = 0;

  always #2 clk = ~clk;

  drc_rail_ctrl #(.STARTUP_CYCLES(8)) u_dut (.clk(clk), .reset(reset), .ext_reset_low(extResetLow),
    .digital_supply_rail(supplyRail), .busCtrlPin(enPins[0]), .rail1_enable_pin(enPins[1]),
    .rail2_enable_pin(enPins[2]), .rail1Sense(sense1), .rail2Sense(sense2), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .rail1_good_out(goodOut[0]), .rail1_good_oe(goodOe[0]),
    .rail2_good_out(goodOut[1]), .rail2_good_oe(goodOe[1]), .all_rails_good_out(goodOut[2]),
    .all_rails_good_oe(goodOe[2]), .railOn(railOn), .faultSuppress(faultSuppress), .refCode(refCode));

  drc_ext_side u_ext (.activeHigh(activeHigh), .holdReset(holdReset), .supplyUp(supplyUp), .wantOn(wantOn),
    .goodOe(goodOe), .goodOut(goodOut), .extResetLow(extResetLow), .supplyRail(supplyRail), .enPins(enPins),
    .goodLevel(goodLevel));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [5:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    avsAddress <= addr;
    avsWritedata <= wdata;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 100) check("bus answer", 32'h1, 32'h0);
    @(posedge clk);
  endtask

  task automatic wait_ref(input logic [9:0] t);
    int n;
    n = 0;
    while (refCode[9:0] !== t && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("rail1 ref", {22'h0, refCode[9:0]}, {22'h0, t});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    conclude();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWritedata} = '0;
    {activeHigh, holdReset, supplyUp, wantOn} = 6'h20;
    sense1 = 12'h200;
    sense2 = 12'h200;
    ra = '{drc_pkg::ADDR_ONOFF, drc_pkg::ADDR_OPER, drc_pkg::ADDR_NOMINAL, drc_pkg::ADDR_MARGHI,
      drc_pkg::ADDR_MARGLO, drc_pkg::ADDR_SAMPLE, drc_pkg::ADDR_GAINS, drc_pkg::ADDR_SLEW};
    rv = '{32'(drc_pkg::ONOFF_RST), 32'(drc_pkg::OPER_RST), 32'(drc_pkg::NOMINAL_RST), 32'(drc_pkg::MARGHI_RST),
      32'(drc_pkg::MARGLO_RST), 32'(drc_pkg::SAMPLE_RST), 32'(drc_pkg::GAINS_RST), 32'(drc_pkg::SLEW_RST)};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus_xfer(1'b0, drc_pkg::ADDR_STATUS, 32'h0);
    check("running", {31'h0, rd[0]}, 32'h0);
    supplyUp <= 1'b1;
    repeat (4) @(posedge clk);
    bus_xfer(1'b0, drc_pkg::ADDR_STATUS, 32'h0);
    check("running", {31'h0, rd[0]}, 32'h0);
    repeat (20) @(posedge clk);
    bus_xfer(1'b0, drc_pkg::ADDR_STATUS, 32'h0);
    check("running", {31'h0, rd[0]}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      bus_xfer(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    bus_xfer(1'b1, 6'h3c, 32'h0);
    bus_xfer(1'b0, 6'h3c, 32'h0);
    check("unmapped read", rd, drc_pkg::UNMAPPED_DATA);
    for (int i = 0; i < 10; i++) begin
      activeHigh <= CFG[i][12];
      wantOn <= CFG[i][2:0];
      repeat (3) @(posedge clk);
      bus_xfer(1'b1, drc_pkg::ADDR_ONOFF, {24'h0, CFG[i][15:8]});
      bus_xfer(1'b1, drc_pkg::ADDR_OPER, {28'h0, CFG[i][7:4]});
      repeat (8) @(posedge clk);
      check("rail on", {30'h0, railOn}, {30'h0, EXP[i]});
      check("good lines", {29'h0, goodLevel}, {29'h0, &EXP[i], EXP[i]});
    end
    holdReset <= 1'b1;
    repeat (8) @(posedge clk);
    check("rail on", {30'h0, railOn}, 32'h0);
    check("good lines", {29'h0, goodLevel}, 32'h0);
    holdReset <= 1'b0;
    repeat (20) @(posedge clk);
    bus_xfer(1'b1, drc_pkg::ADDR_ONOFF, 32'h11);
    repeat (4) @(posedge clk);
    check("rail on", {30'h0, railOn}, 32'h3);
    bus_xfer(1'b1, drc_pkg::ADDR_SLEW, 32'h1);
    bus_xfer(1'b1, drc_pkg::ADDR_OPER, 32'h3);
    repeat (2) @(posedge clk);
    check("ref stepped", {31'h0, refCode[9:0] === 10'h220}, 32'h0);
    wait_ref(10'h220);
    check("suppress", {30'h0, faultSuppress}, 32'h0);
    bus_xfer(1'b1, drc_pkg::ADDR_OPER, 32'hd);
    wait_ref(10'h1e0);
    check("suppress", {30'h0, faultSuppress}, 32'h3);
    bus_xfer(1'b1, drc_pkg::ADDR_OPER, 32'h1);
    wait_ref(10'h200);
    check("suppress", {30'h0, faultSuppress}, 32'h0);
    bus_xfer(1'b1, drc_pkg::ADDR_VIDCODE, 32'h210);
    bus_xfer(1'b1, drc_pkg::ADDR_VIDSETUP, 32'h1);
    wait_ref(10'h210);
    bus_xfer(1'b1, drc_pkg::ADDR_VIDSETUP, 32'h0);
    wait_ref(10'h200);
    sense1 <= 12'h228;
    for (int i = 0; i < 6; i++) begin
      bus_xfer(1'b1, drc_pkg::ADDR_GAINS, GAIN[i]);
      repeat (600) @(posedge clk);
      bus_xfer(1'b0, drc_pkg::ADDR_STATUS, 32'h0);
      check("saturated", {31'h0, rd[5]}, {31'h0, i == 3 || i == 4});
    end
    bus_xfer(1'b1, drc_pkg::ADDR_GAINS, 32'h3f);
    repeat (1800) @(posedge clk);
    check("ref slewed up", {31'h0, refCode[9:0] > 10'h200}, 32'h1);
    bus_xfer(1'b1, drc_pkg::ADDR_GAINS, 32'h2a);
    conclude();
  end
endmodule

bind drc_rail_ctrl drc_rail_ctrl_props #(.NUM_RAILS(NUM_RAILS), .STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
  .clk(clk), .reset(reset), .ext_reset_low(ext_reset_low), .digital_supply_rail(digital_supply_rail),
  .rail1_enable_pin(rail1_enable_pin), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rail1_good_out(rail1_good_out), .rail1_good_oe(rail1_good_oe),
  .rail2_good_out(rail2_good_out), .rail2_good_oe(rail2_good_oe), .all_rails_good_out(all_rails_good_out),
  .all_rails_good_oe(all_rails_good_oe), .railOn(railOn), .refCode(refCode));
